//--- parallel_load_serial_shift_register.v
// Purpose: Eight-stage parallel-in, serial-out shift register with dual shift clocks
// Assumes: All pin inputs are asynchronous to clk_sys and much slower than it
// Notes: Load is level sensitive; shifting uses the OR of both clocks, edge detected
`timescale 1ns/1ns
`include "shift_reg_defs.vh"

// Behaviour
// RULE_01: While load strobe is low, all parallel inputs are copied into the stages.
// RULE_02: No shifting happens while the load strobe is held low.
// RULE_03: Last stage drives true and complemented outputs, highest bit first.
// RULE_04: Each shift moves serial input into stage zero, others take previous stage.
// RULE_05: One shift per rising edge on either clock while load is high.
// RULE_06: Both clocks work alone or together through one combined clock.
// RULE_07: A clock held high acts as a disable for the other clock.
// RULE_08: Driver raises an enable clock only while the other clock is high.
// RULE_09: Combined clock is OR of both inputs, with one sampled edge detector.
module parallel_load_serial_shift_register
#(
	parameter WIDTH = `SR_WIDTH
)
(
	input wire clk_sys,
	input wire reset_n,
	input wire load_strobe_n,
	input wire [WIDTH-1:0] parallel_in,
	input wire serial_in,
	input wire shift_clock_a,
	input wire shift_clock_b,
	output reg last_stage_out,
	output reg last_stage_out_n
);
	reg [2:0] load_sync_ff;
	reg [2:0] ser_sync_ff;
	reg [2:0] clka_sync_ff;
	reg [2:0] clkb_sync_ff;
	reg [WIDTH-1:0] par_sync1_ff;
	reg [WIDTH-1:0] par_sync2_ff;
	reg [WIDTH-1:0] par_sync3_ff;
	reg [WIDTH-1:0] par_ff;
	reg [WIDTH-1:0] nxt_par;
	wire [WIDTH-1:0] par_agree;
	reg load_n_ff;
	reg clka_ff;
	reg clkb_ff;
	reg comb_clk_ff;
	reg [WIDTH-1:0] stage_ff;
	reg [WIDTH-1:0] nxt_stage;
	reg nxt_load_n;
	reg nxt_clka;
	reg nxt_clkb;
	wire comb_clk;
	wire shift_edge;

	// Three-flop synchronisers; every level except serial_in is accepted once stages two and three agree
	always @(posedge clk_sys or negedge reset_n)
	begin
		if (!reset_n)
		begin
			// Load restarts at its idle high level so release causes no false load
			load_sync_ff <= `SR_SYNC_SET;
			ser_sync_ff <= `SR_SYNC_RESET;
			clka_sync_ff <= `SR_SYNC_RESET;
			clkb_sync_ff <= `SR_SYNC_RESET;
			par_sync1_ff <= `SR_STAGE_RESET;
			par_sync2_ff <= `SR_STAGE_RESET;
			par_sync3_ff <= `SR_STAGE_RESET;
		end
		else
		begin
			load_sync_ff <= {load_sync_ff[1:0], load_strobe_n};
			ser_sync_ff <= {ser_sync_ff[1:0], serial_in};
			clka_sync_ff <= {clka_sync_ff[1:0], shift_clock_a};
			clkb_sync_ff <= {clkb_sync_ff[1:0], shift_clock_b};
			par_sync1_ff <= parallel_in;
			par_sync2_ff <= par_sync1_ff;
			par_sync3_ff <= par_sync2_ff;
		end
	end

	// Per-bit agreement of the later stages; a settling bit keeps its old level
	assign par_agree = ~(par_sync2_ff ^ par_sync3_ff);

	// Filtered parallel word, each bit accepted on its own
	always @*
	begin
		nxt_par = (par_ff & ~par_agree) | (par_sync3_ff & par_agree);
	end

	// Filtered levels only change when the two later stages agree
	always @*
	begin
		nxt_load_n = load_n_ff;
		nxt_clka = clka_ff;
		nxt_clkb = clkb_ff;
		if (load_sync_ff[1] == load_sync_ff[2])
			nxt_load_n = load_sync_ff[2];
		if (clka_sync_ff[1] == clka_sync_ff[2])
			nxt_clka = clka_sync_ff[2];
		if (clkb_sync_ff[1] == clkb_sync_ff[2])
			nxt_clkb = clkb_sync_ff[2];
	end

	// Combined clock: a high clock masks the other, so either acts as an enable
	assign comb_clk = clka_ff | clkb_ff; // see RULE_09 see RULE_06 see RULE_07
	// Relies on the driver raising an enable only while the other clock is high
	assign shift_edge = comb_clk & ~comb_clk_ff; // see RULE_05 see RULE_08

	// Load has priority and holds off every shift while low
	always @*
	begin
		nxt_stage = stage_ff;
		if (!load_n_ff)
			nxt_stage = par_ff; // see RULE_01 see RULE_02
		else if (shift_edge)
			nxt_stage = {stage_ff[WIDTH-2:0], ser_sync_ff[2]}; // see RULE_04
	end

	// Stage register and edge history; outputs come straight from flip-flops
	always @(posedge clk_sys or negedge reset_n)
	begin
		if (!reset_n)
		begin
			load_n_ff <= `SR_BIT_HIGH;
			clka_ff <= `SR_BIT_LOW;
			clkb_ff <= `SR_BIT_LOW;
			comb_clk_ff <= `SR_BIT_LOW;
			par_ff <= `SR_STAGE_RESET;
			stage_ff <= `SR_STAGE_RESET;
			last_stage_out <= `SR_BIT_LOW;
			last_stage_out_n <= `SR_BIT_HIGH;
		end
		else
		begin
			load_n_ff <= nxt_load_n;
			clka_ff <= nxt_clka;
			clkb_ff <= nxt_clkb;
			// A clock edge seen during load is consumed, never replayed later
			comb_clk_ff <= comb_clk;
			// Same latency as the load level, so both arrive in one cycle
			par_ff <= nxt_par;
			stage_ff <= nxt_stage;
			last_stage_out <= nxt_stage[WIDTH-1]; // see RULE_03
			last_stage_out_n <= ~nxt_stage[WIDTH-1]; // see RULE_03
		end
	end
endmodule

//--- shift_reg_defs.vh
// Purpose: Constants for the parallel-load serial shift register
// Assumes: Included by name from the design file
// Notes: Definitions only
`ifndef SHIFT_REG_DEFS_VH
`define SHIFT_REG_DEFS_VH
`define SR_WIDTH 8
`define SR_SYNC_STAGES 3
`define SR_SYNC_RESET 3'h0
`define SR_SYNC_SET 3'h7
`define SR_STAGE_RESET 8'h00
`define SR_BIT_LOW 1'b0
`define SR_BIT_HIGH 1'b1
`endif

//--- sr_chk.sv
// Purpose: Port checker for the shift register
// Assumes: Load and clock levels stay put for several cycles
// Notes: Windows cover the three-flop input delay
`timescale 1ns/1ns
module sr_chk #(parameter WIDTH = 8)
(
	input wire clk_sys, reset_n, load_strobe_n, serial_in, shift_clock_a, shift_clock_b,
	input wire last_stage_out, last_stage_out_n,
	input wire [WIDTH-1:0] parallel_in
);
	default clocking @(posedge clk_sys); endclocking
	default disable iff (!reset_n);
	// Combined clock level, stable windows mean no shift is pending
	wire c = shift_clock_a | shift_clock_b;
	a_out_pair: assert property (last_stage_out_n != last_stage_out) else $error("pair");
	a_load_copy: assert property ((!load_strobe_n && $stable(parallel_in))[*6] |->
		last_stage_out == parallel_in[WIDTH-1]) else $error("load");
	a_load_noshift: assert property ((!load_strobe_n && $stable(parallel_in))[*8] |->
		$stable(last_stage_out)) else $error("shifted in load");
	a_idle_hold: assert property ((load_strobe_n && !c)[*8] |-> $stable(last_stage_out))
		else $error("idle");
	a_enable_hold: assert property ((load_strobe_n && c)[*8] |-> $stable(last_stage_out))
		else $error("enable");
	a_reset_out: assert property (disable iff (1'b0) !reset_n |-> !last_stage_out) else $error("rst");
endmodule
bind parallel_load_serial_shift_register sr_chk #(.WIDTH(WIDTH)) i_chk (.*);

//--- ctl_model.sv
// Purpose: Controller that loads and clocks the register
// Assumes: Each level is held eight cycles
// Notes: Clocks low and load high from time zero
`timescale 1ns/1ns
module ctl_model
(
	input wire clk_sys,
	output reg load_strobe_n = 1'b1,
	output reg [7:0] parallel_in = 8'h00,
	output reg serial_in = 1'b0,
	output reg shift_clock_a = 1'b0,
	output reg shift_clock_b = 1'b0
);
	// Long hold keeps every level past the input filter
	task step(input bit l, input bit [7:0] p, input bit a, input bit b, input bit s);
		@(posedge clk_sys);
		load_strobe_n <= l;
		parallel_in <= p;
		serial_in <= s;
		shift_clock_a <= a;
		shift_clock_b <= b;
		repeat (7) @(posedge clk_sys);
	endtask
endmodule

//--- parallel_load_serial_shift_register_bench.sv
// Purpose: Self-checking bench for the shift register
// Assumes: Expected bits queue up in driving order
// Notes: Clock pairs walk single, dual and enable use
`timescale 1ns/1ns
`define CHK(n,e,s) begin check_count++; if ((e) !== (s)) begin n_errors++; \
	$display("[ERR] %s exp %b got %b", n, e, s); end end
module parallel_load_serial_shift_register_bench;
	reg clk_sys = 0;
	reg reset_n = 0;
	wire l, a, b, s, q, qn;
	wire [7:0] p;
	int n_errors = 0, check_count = 0, i, j;
	bit e, o;
	bit [7:0] m;
	bit [31:0] r;
	bit qe [$];
	// Clock pairs: a, b, both, then a held high as enable, then b held high as enable
	localparam bit [23:0] SQ = 24'h84_cb74;
	always #10 clk_sys = ~clk_sys;
	ctl_model i_ctl (.clk_sys(clk_sys), .load_strobe_n(l), .parallel_in(p), .serial_in(s),
		.shift_clock_a(a), .shift_clock_b(b));
	parallel_load_serial_shift_register i_dut (.clk_sys(clk_sys), .reset_n(reset_n),
		.load_strobe_n(l), .parallel_in(p), .serial_in(s), .shift_clock_a(a),
		.shift_clock_b(b), .last_stage_out(q), .last_stage_out_n(qn));
	task go(input bit ln, input bit av, input bit bv, input bit sv, input bit [7:0] pv);
		i_ctl.step(ln, pv, av, bv, sv);
		if (!ln)
			m = pv;
		else if ((av | bv) && !o)
			m = {m[6:0], sv};
		o = av | bv;
		qe.push_back(m[7]);
	endtask
	task test_done;
		$display("checks %0d errors %0d", check_count, n_errors);
		if (n_errors == 0 && check_count > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask
	// Monitor takes the oldest note once the outputs have settled
	always @(negedge clk_sys)
		if (qe.size())
		begin
			e = qe.pop_front();
			`CHK("out", e, q)
			`CHK("out_n", ~e, qn)
		end
	initial
	begin
		repeat (5000) @(posedge clk_sys);
		n_errors++;
		test_done;
	end
	initial
	begin
		r = $urandom(32'h65a1_5a58);
		repeat (6) @(posedge clk_sys);
		reset_n <= 1;
		repeat (5) @(posedge clk_sys);
		for (i = 0; i < 4; i++)
		begin
			r = $urandom;
			go(0, 0, 0, 0, r[7:0]);
			go(0, 1, 0, 0, r[15:8]);
			go(1, 0, 0, 0, r[15:8]);
			for (j = 23; j >= 0; j--)
				go(1, SQ[2*(j%12)+1], SQ[2*(j%12)], r[j], r[31:24]);
		end
		test_done;
	end
endmodule
